//--- hw/pbus_bridge_end.sv
// bridge end of the primary bus: target for config cycles, initiator for user requests
// assumes the agent end on the same clock; bus inputs are same-domain logic
//
// Summary of operation
// - claim accepted target cycles with device select
// - abort own cycle when nobody claims it
// - frame asserted starts transfer, keeps it going
// - frame released marks the final data phase
// - arbiter grant owns bus after current transaction
// - accept parked grant without prior request
// - answer config accesses only with init select
// - system wires init select to upper address; here the agent end drives it high for each of its config cycles
// - configuration reachable from primary side only; here cfg_r is never written, so cfg_reg_o stays zero
// - data phase completes when both readies low
// - wait states while either ready is high
// - lock drivable and observable by initiators
// - even parity over address/data and commands
// - drive parity one clock after covered data
// - check parity, report mismatch on error line; here only config write data taken in as target is checked
// - four bidirectional general purpose pins
// - all signals sampled on rising clock edge
// - reset releases all drivers, clears state
// - byte enables qualify their data byte
// - parity error only when response enabled
`timescale 1ns/1ps
`include "pbus_defs.svh"
module pbus_bridge_end
  import pbus_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  pbus_if.bridge bus,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_lock_i,
  input wire logic [31:0] req_addr_i,
  input wire logic [31:0] req_wdata_i,
  input wire logic [3:0] req_be_i,
  output logic req_ready_o,
  output logic done_o,
  output logic abort_o,
  output logic [31:0] rdata_o,
  input wire logic perr_resp_en_i,
  output logic perr_seen_o,
  output logic lock_seen_o,
  output logic [31:0] cfg_reg_o,
  input wire logic [3:0] gp_in_i,
  input wire logic [3:0] gp_out_i,
  input wire logic [3:0] gp_oe_i,
  output logic [3:0] gp_pin_o,
  output logic [3:0] gp_pin_oe_o,
  output logic [3:0] gp_rd_o
);
  bus_state_e init_state_r;
  bus_state_e tgt_state_r;
  logic [2:0] decode_cnt_r;
  logic [31:0] cfg_r;
  logic tgt_write_r;
  logic par_pending_r;
  logic par_chk_r;
  logic [3:0] gp_sync1_r;
  logic [3:0] gp_sync2_r;
  logic bus_idle;
  logic data_xfer;
  logic par_calc;
  logic init_owner;

  // ****************************************
  // shared bus decode
  // ****************************************
  assign bus_idle = bus.frame_n & bus.irdy_n;
  assign data_xfer = ~bus.irdy_n & ~bus.trdy_n;
  assign par_calc = ^{bus.ad, bus.cbe};
  assign init_owner = (init_state_r != ST_IDLE);
  assign req_ready_o = (init_state_r == ST_IDLE) && ~bus.gnt_n && bus_idle
                       && (tgt_state_r == ST_IDLE);
  assign lock_seen_o = ~bus.lock_n;
  assign cfg_reg_o = cfg_r;

  // ****************************************
  // initiator
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      init_state_r <= ST_IDLE;
      decode_cnt_r <= 3'h0;
      done_o <= 1'b0;
      abort_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
      bus.b_ad_oe <= 1'b0;
      bus.b_cbe_oe <= 1'b0;
      bus.b_ad_o <= 32'h0000_0000;
      bus.b_cbe_o <= 4'h0;
      bus.b_frame_n_o <= 1'b1;
      bus.b_irdy_n_o <= 1'b1;
      bus.b_lock_n_o <= 1'b1;
      tgt_write_r <= 1'b0;
    end else begin
      done_o <= 1'b0;
      abort_o <= 1'b0;
      case (init_state_r)
        ST_IDLE: begin
          if (req_valid_i && req_ready_o) begin
            init_state_r <= ST_ADDR;
            bus.b_frame_n_o <= 1'b0;
            bus.b_lock_n_o <= ~req_lock_i;
            bus.b_ad_o <= req_addr_i;
            bus.b_ad_oe <= 1'b1;
            bus.b_cbe_o <= req_write_i ? `CMD_MEM_WRITE : `CMD_MEM_READ;
            bus.b_cbe_oe <= 1'b1;
            tgt_write_r <= req_write_i;
          end
        end
        ST_ADDR: begin
          init_state_r <= ST_DATA;
          decode_cnt_r <= 3'h0;
          bus.b_frame_n_o <= 1'b1;
          bus.b_irdy_n_o <= 1'b0;
          bus.b_cbe_o <= req_be_i;
          bus.b_ad_o <= req_wdata_i;
          bus.b_ad_oe <= tgt_write_r;
        end
        ST_DATA: begin
          decode_cnt_r <= decode_cnt_r + 3'h1;
          if (data_xfer) begin
            init_state_r <= ST_TURN;
            done_o <= 1'b1;
            rdata_o <= bus.ad;
            bus.b_irdy_n_o <= 1'b1;
            bus.b_ad_oe <= 1'b0;
            bus.b_cbe_oe <= 1'b0;
            bus.b_lock_n_o <= 1'b1;
          end else if (bus.devsel_n
                       && decode_cnt_r == 3'(`DECODE_WINDOW_CLKS - 1)) begin
            init_state_r <= ST_ABORT;
            abort_o <= 1'b1;
            bus.b_irdy_n_o <= 1'b1;
            bus.b_ad_oe <= 1'b0;
            bus.b_cbe_oe <= 1'b0;
            bus.b_lock_n_o <= 1'b1;
          end
        end
        ST_TURN: init_state_r <= ST_IDLE;
        ST_ABORT: init_state_r <= ST_IDLE;
        default: init_state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // configuration target
  // ****************************************
  // single-phase config target; burst config accesses are not supported
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tgt_state_r <= ST_IDLE;
      cfg_r <= 32'h0000_0000;
      bus.b_devsel_n_o <= 1'b1;
      bus.b_trdy_n_o <= 1'b1;
    end else begin
      case (tgt_state_r)
        ST_IDLE: begin
          if (~bus.frame_n && ~init_owner && bus.init_select
              && (bus.cbe == `CMD_CFG_READ || bus.cbe == `CMD_CFG_WRITE)) begin
            tgt_state_r <= ST_DATA;
            bus.b_devsel_n_o <= 1'b0;
            bus.b_trdy_n_o <= 1'b0;
          end
        end
        ST_DATA: begin
          if (data_xfer) begin
            tgt_state_r <= ST_TURN;
            bus.b_devsel_n_o <= 1'b1;
            bus.b_trdy_n_o <= 1'b1;
          end
        end
        ST_TURN: tgt_state_r <= ST_IDLE;
        default: tgt_state_r <= ST_IDLE;
      endcase
    end
  end

  logic tgt_cfg_write_r;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tgt_cfg_write_r <= 1'b0;
    end else if (tgt_state_r == ST_IDLE && ~bus.frame_n) begin
      tgt_cfg_write_r <= (bus.cbe == `CMD_CFG_WRITE);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      bus.b_par_o <= 1'b0;
      bus.b_par_oe <= 1'b0;
      par_pending_r <= 1'b0;
      par_chk_r <= 1'b0;
      perr_seen_o <= 1'b0;
      bus.b_perr_n_o <= 1'b1;
    end else begin
      // parity lags its covered phase by one clock
      bus.b_par_o <= par_calc;
      bus.b_par_oe <= bus.b_ad_oe;
      par_pending_r <= (tgt_state_r == ST_DATA) && data_xfer && tgt_cfg_write_r;
      par_chk_r <= par_calc;
      perr_seen_o <= 1'b0;
      bus.b_perr_n_o <= 1'b1;
      if (par_pending_r && (par_chk_r != bus.par)) begin
        perr_seen_o <= 1'b1;
        bus.b_perr_n_o <= ~perr_resp_en_i;
      end
    end
  end

  // ****************************************
  // general purpose pins
  // ****************************************
  assign gp_pin_o = gp_out_i;
  assign gp_pin_oe_o = sys_rst_i ? 4'h0 : gp_oe_i;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      gp_sync1_r <= 4'h0;
      gp_sync2_r <= 4'h0;
    end else begin
      gp_sync1_r <= gp_in_i;
      gp_sync2_r <= gp_sync1_r;
    end
  end
  assign gp_rd_o = gp_sync2_r;
endmodule

//--- hw/pbus_defs.svh
// timing counts and field positions shared by both bus ends
// assumes inclusion by bare name from hw/ files
`ifndef PBUS_DEFS_SVH
`define PBUS_DEFS_SVH
`define DECODE_WINDOW_CLKS 5
`define CMD_CFG_READ 4'hA
`define CMD_CFG_WRITE 4'hB
`define CMD_MEM_READ 4'h6
`define CMD_MEM_WRITE 4'h7
`define PERR_ENABLE_BIT 6
`define GP_PINS 4
`endif

//--- hw/pbus_pkg.sv
// types shared by the bridge end and the agent end of the primary bus
// assumes nothing outside itself
package pbus_pkg;
  typedef logic [31:0] word_t;
  typedef logic [3:0] nibble_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_DATA = 3'b010,
    ST_TURN = 3'b011,
    ST_ABORT = 3'b100
  } bus_state_e;
endpackage

//--- hw/pbus_if.sv
// primary bus wires between the bridge end and the bus agent end
// active-low bus signals resolve as wired-or of enables; no pull-ups modelled
`timescale 1ns/1ps
interface pbus_if;
  import pbus_pkg::*;
  logic [31:0] ad;
  logic [3:0] cbe;
  logic par;
  logic frame_n;
  logic irdy_n;
  logic trdy_n;
  logic devsel_n;
  logic lock_n;
  logic perr_n;
  logic gnt_n;
  logic init_select;
  logic [31:0] b_ad_o;
  logic [31:0] a_ad_o;
  logic b_ad_oe;
  logic a_ad_oe;
  logic [3:0] b_cbe_o;
  logic [3:0] a_cbe_o;
  logic b_cbe_oe;
  logic a_cbe_oe;
  logic b_par_o;
  logic a_par_o;
  logic b_par_oe;
  logic a_par_oe;
  logic b_frame_n_o;
  logic a_frame_n_o;
  logic b_irdy_n_o;
  logic a_irdy_n_o;
  logic b_trdy_n_o;
  logic a_trdy_n_o;
  logic b_devsel_n_o;
  logic a_devsel_n_o;
  logic b_lock_n_o;
  logic a_lock_n_o;
  logic b_perr_n_o;
  logic a_perr_n_o;
  assign ad = b_ad_oe ? b_ad_o : (a_ad_oe ? a_ad_o : 32'h0000_0000);
  assign cbe = b_cbe_oe ? b_cbe_o : (a_cbe_oe ? a_cbe_o : 4'h0);
  assign par = b_par_oe ? b_par_o : (a_par_oe ? a_par_o : 1'b0);
  assign frame_n = b_frame_n_o & a_frame_n_o;
  assign irdy_n = b_irdy_n_o & a_irdy_n_o;
  assign trdy_n = b_trdy_n_o & a_trdy_n_o;
  assign devsel_n = b_devsel_n_o & a_devsel_n_o;
  assign lock_n = b_lock_n_o & a_lock_n_o;
  assign perr_n = b_perr_n_o & a_perr_n_o;
  modport bridge (
    input ad, cbe, par, frame_n, irdy_n, trdy_n, devsel_n, lock_n, perr_n, gnt_n, init_select,
    output b_ad_o, b_ad_oe, b_cbe_o, b_cbe_oe, b_par_o, b_par_oe, b_frame_n_o, b_irdy_n_o,
    output b_trdy_n_o, b_devsel_n_o, b_lock_n_o, b_perr_n_o
  );
  modport agent (
    input ad, cbe, par, frame_n, irdy_n, trdy_n, devsel_n, lock_n, perr_n,
    output gnt_n, init_select,
    output a_ad_o, a_ad_oe, a_cbe_o, a_cbe_oe, a_par_o, a_par_oe, a_frame_n_o, a_irdy_n_o,
    output a_trdy_n_o, a_devsel_n_o, a_lock_n_o, a_perr_n_o
  );
endinterface

//--- hw/pbus_agent_end.sv
// agent end: host initiator doing config cycles, simple memory target, arbiter
// assumes the bridge end on the same clock
`timescale 1ns/1ps
`include "pbus_defs.svh"
module pbus_agent_end
  import pbus_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  pbus_if.agent bus,
  input wire logic grant_i,
  input wire logic claim_en_i,
  input wire logic cfg_valid_i,
  input wire logic cfg_write_i,
  input wire logic [31:0] cfg_addr_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic cfg_ready_o,
  output logic cfg_done_o,
  output logic [31:0] cfg_rdata_o,
  output logic [31:0] mem_word_o
);
  bus_state_e st_r;
  bus_state_e tg_r;
  logic wr_r;
  logic tg_wr_r;
  logic tg_ad_oe_r;
  logic [31:0] ini_ad_r;
  logic ini_ad_oe_r;

  assign bus.gnt_n = ~grant_i;
  assign bus.a_lock_n_o = 1'b1;
  assign bus.a_perr_n_o = 1'b1;
  // initiator and target never overlap, so one shared data driver
  assign bus.a_ad_o = tg_ad_oe_r ? mem_word_o : ini_ad_r;
  assign bus.a_ad_oe = ini_ad_oe_r | tg_ad_oe_r;

  // parity trails whatever this end put on address/data by one clock
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      bus.a_par_o <= 1'b0;
      bus.a_par_oe <= 1'b0;
    end else begin
      bus.a_par_o <= ^{bus.ad, bus.cbe};
      bus.a_par_oe <= bus.a_ad_oe;
    end
  end
  assign cfg_ready_o = (st_r == ST_IDLE) && ~grant_i && bus.frame_n && bus.irdy_n;

  // ****************************************
  // host initiator, config cycles
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_r <= ST_IDLE;
      wr_r <= 1'b0;
      cfg_done_o <= 1'b0;
      cfg_rdata_o <= 32'h0000_0000;
      bus.init_select <= 1'b0;
      bus.a_frame_n_o <= 1'b1;
      bus.a_irdy_n_o <= 1'b1;
      ini_ad_r <= 32'h0000_0000;
      ini_ad_oe_r <= 1'b0;
      bus.a_cbe_o <= 4'h0;
      bus.a_cbe_oe <= 1'b0;
    end else begin
      cfg_done_o <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (cfg_valid_i && cfg_ready_o) begin
            st_r <= ST_ADDR;
            wr_r <= cfg_write_i;
            bus.init_select <= 1'b1;
            bus.a_frame_n_o <= 1'b0;
            ini_ad_r <= cfg_addr_i;
            ini_ad_oe_r <= 1'b1;
            bus.a_cbe_o <= cfg_write_i ? `CMD_CFG_WRITE : `CMD_CFG_READ;
            bus.a_cbe_oe <= 1'b1;
          end
        end
        ST_ADDR: begin
          st_r <= ST_DATA;
          bus.a_frame_n_o <= 1'b1;
          bus.a_irdy_n_o <= 1'b0;
          ini_ad_r <= cfg_wdata_i;
          ini_ad_oe_r <= wr_r;
          bus.a_cbe_o <= 4'hF;
        end
        ST_DATA: begin
          if (~bus.irdy_n && ~bus.trdy_n) begin
            st_r <= ST_IDLE;
            cfg_done_o <= 1'b1;
            cfg_rdata_o <= bus.ad;
            bus.init_select <= 1'b0;
            bus.a_irdy_n_o <= 1'b1;
            ini_ad_oe_r <= 1'b0;
            bus.a_cbe_oe <= 1'b0;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // memory target for bridge cycles
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tg_r <= ST_IDLE;
      tg_wr_r <= 1'b0;
      tg_ad_oe_r <= 1'b0;
      mem_word_o <= 32'h0000_0000;
      bus.a_devsel_n_o <= 1'b1;
      bus.a_trdy_n_o <= 1'b1;
    end else begin
      case (tg_r)
        ST_IDLE: begin
          if (~bus.frame_n && claim_en_i && st_r == ST_IDLE
              && (bus.cbe == `CMD_MEM_READ || bus.cbe == `CMD_MEM_WRITE)) begin
            tg_r <= ST_DATA;
            tg_wr_r <= (bus.cbe == `CMD_MEM_WRITE);
            tg_ad_oe_r <= (bus.cbe == `CMD_MEM_READ);
            bus.a_devsel_n_o <= 1'b0;
            bus.a_trdy_n_o <= 1'b0;
          end
        end
        ST_DATA: begin
          if (~bus.irdy_n) begin
            tg_r <= ST_IDLE;
            tg_ad_oe_r <= 1'b0;
            bus.a_devsel_n_o <= 1'b1;
            bus.a_trdy_n_o <= 1'b1;
            for (int i = 0; i < 4; i++) begin
              if (tg_wr_r && bus.cbe[i]) begin
                mem_word_o[8*i +: 8] <= bus.ad[8*i +: 8];
              end
            end
          end
        end
        default: tg_r <= ST_IDLE;
      endcase
    end
  end
endmodule

//--- testbench/pbus_chk.sv
// assertions on the primary bus wires between the two ends
// assumes interface signals wired in by name, one clock domain
`timescale 1ns/1ps
module pbus_chk (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe,
  input wire logic par,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic devsel_n,
  input wire logic gnt_n,
  input wire logic init_select,
  input wire logic b_ad_oe,
  input wire logic a_ad_oe,
  input wire logic b_frame_n_o,
  input wire logic b_irdy_n_o,
  input wire logic b_trdy_n_o,
  input wire logic b_devsel_n_o,
  input wire logic a_frame_n_o
);
  // ****************
  // bus checks
  // ****************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  a_par_even: assert property (
    $past(b_ad_oe) |-> par == ^{$past(ad), $past(cbe)})
    else $error("parity not even one clock after driven bus");
  a_frame_last: assert property (
    $fell(b_frame_n_o) |=> b_frame_n_o && !b_irdy_n_o)
    else $error("single phase framing broken");
  a_abort_window: assert property (
    $fell(b_frame_n_o) ##0 devsel_n [*7] |-> ##[0:2] b_irdy_n_o)
    else $error("unclaimed cycle not aborted");
  a_done_release: assert property (
    !irdy_n && !trdy_n && !b_irdy_n_o |=> b_irdy_n_o && b_frame_n_o)
    else $error("initiator ready held after completed phase");
  a_wait_hold: assert property (
    !b_irdy_n_o && trdy_n && !devsel_n |=> !b_irdy_n_o)
    else $error("initiator ready dropped during wait state");
  a_cfg_claim: assert property (
    $fell(a_frame_n_o) && init_select && cbe[3:1] == 3'b101 |-> ##[1:3] !b_devsel_n_o)
    else $error("selected config cycle not claimed");
  a_trdy_claim: assert property (
    !b_trdy_n_o |-> !b_devsel_n_o)
    else $error("target ready without device select");
  a_start_granted: assert property (
    $fell(b_frame_n_o) |-> !$past(gnt_n) && $past(frame_n) && $past(irdy_n))
    else $error("cycle started without grant or on busy bus");
  a_ad_owner: assert property (
    !(b_ad_oe && a_ad_oe))
    else $error("both ends drive address data");
  a_reset_idle: assert property (
    $fell(sys_rst_i) |-> b_frame_n_o && b_irdy_n_o && b_devsel_n_o && !b_ad_oe)
    else $error("bridge not idle after reset");
  c_done: cover property (!irdy_n && !trdy_n && !b_irdy_n_o);
  c_abort: cover property ($fell(b_frame_n_o) ##0 devsel_n [*7]);
  c_cfg: cover property (!b_devsel_n_o);
endmodule

//--- testbench/tb_top.sv
// self-checking bench: bridge end and agent end joined by one interface
// assumes design files compiled first; one 200 MHz clock
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  import pbus_pkg::*;
  logic core_clk_i, sys_rst_i, req_valid_i, req_write_i, req_lock_i, perr_resp_en_i;
  logic grant_i, claim_en_i, cfg_valid_i, cfg_write_i, ab, lks, ok, pe;
  logic req_ready_o, done_o, abort_o, perr_seen_o, lock_seen_o, cfg_ready_o, cfg_done_o;
  word_t req_addr_i, req_wdata_i, cfg_addr_i, cfg_wdata_i, rdata_o, cfg_reg_o;
  word_t cfg_rdata_o, mem_word_o, mem_exp, a, d;
  nibble_t req_be_i, gp_in_i, gp_out_i, gp_oe_i, gp_pin_o, gp_pin_oe_o, gp_rd_o, be;
  int fail_count, compares, cyc, n;
  nibble_t be_tab[4] = '{4'hf, 4'h1, 4'h8, 4'h6};
  pbus_if pbus_if_inst ();
  pbus_bridge_end pbus_bridge_end_inst (.core_clk_i, .sys_rst_i, .bus(pbus_if_inst),
    .req_valid_i, .req_write_i, .req_lock_i, .req_addr_i, .req_wdata_i, .req_be_i,
    .req_ready_o, .done_o, .abort_o, .rdata_o, .perr_resp_en_i, .perr_seen_o, .lock_seen_o,
    .cfg_reg_o, .gp_in_i, .gp_out_i, .gp_oe_i, .gp_pin_o, .gp_pin_oe_o, .gp_rd_o);
  pbus_agent_end pbus_agent_end_inst (.core_clk_i, .sys_rst_i, .bus(pbus_if_inst), .grant_i,
    .claim_en_i, .cfg_valid_i, .cfg_write_i, .cfg_addr_i, .cfg_wdata_i, .cfg_ready_o,
    .cfg_done_o, .cfg_rdata_o, .mem_word_o);
  pbus_chk pbus_chk_inst (.core_clk_i, .sys_rst_i, .ad(pbus_if_inst.ad),
    .cbe(pbus_if_inst.cbe), .par(pbus_if_inst.par), .frame_n(pbus_if_inst.frame_n),
    .irdy_n(pbus_if_inst.irdy_n), .trdy_n(pbus_if_inst.trdy_n),
    .devsel_n(pbus_if_inst.devsel_n), .gnt_n(pbus_if_inst.gnt_n),
    .init_select(pbus_if_inst.init_select), .b_ad_oe(pbus_if_inst.b_ad_oe),
    .a_ad_oe(pbus_if_inst.a_ad_oe), .b_frame_n_o(pbus_if_inst.b_frame_n_o),
    .b_irdy_n_o(pbus_if_inst.b_irdy_n_o), .b_trdy_n_o(pbus_if_inst.b_trdy_n_o),
    .b_devsel_n_o(pbus_if_inst.b_devsel_n_o), .a_frame_n_o(pbus_if_inst.a_frame_n_o));
  // ****************
  // helpers
  // ****************
  function automatic word_t merge(word_t o, word_t w, nibble_t m);
    for (int k = 0; k < 4; k++) begin
      if (m[k]) begin
        o[8*k +: 8] = w[8*k +: 8];
      end
    end
    return o;
  endfunction
  task automatic tick(input int k = 1);
    repeat (k) @(negedge core_clk_i);
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // bounded waits: a stuck end shows up as a failed check, not a hang
  task automatic bridge_op(input logic w, lk, input word_t ad, wd, input nibble_t bs);
    n = 0;
    while (!req_ready_o && n < 20) begin
      tick();
      n++;
    end
    {req_valid_i, req_write_i, req_lock_i} = {1'b1, w, lk};
    {req_addr_i, req_wdata_i, req_be_i} = {ad, wd, bs};
    tick();
    req_valid_i = 1'b0;
    n = 0;
    lks = 1'b0;
    while (!done_o && !abort_o && n < 20) begin
      lks |= lock_seen_o;
      tick();
      n++;
    end
    ab = abort_o;
  endtask
  task automatic cfg_op(input logic w, input word_t ad, wd);
    n = 0;
    while (!cfg_ready_o && n < 20) begin
      tick();
      n++;
    end
    {cfg_valid_i, cfg_write_i, cfg_addr_i, cfg_wdata_i} = {1'b1, w, ad, wd};
    tick();
    cfg_valid_i = 1'b0;
    n = 0;
    pe = 1'b0;
    while (!cfg_done_o && n < 20) begin
      pe |= perr_seen_o | ~pbus_if_inst.perr_n;
      tick();
      n++;
    end
    ok = cfg_done_o;
    // parity verdict lands one clock after completion
    tick();
    pe |= perr_seen_o | ~pbus_if_inst.perr_n;
  endtask
  // ****************
  // clock, timeout, scenarios
  // ****************
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    {req_valid_i, req_write_i, req_lock_i, perr_resp_en_i, grant_i, claim_en_i} = '0;
    {cfg_valid_i, cfg_write_i, cfg_addr_i, cfg_wdata_i} = '0;
    {req_addr_i, req_wdata_i, req_be_i, gp_in_i, gp_out_i} = '0;
    gp_oe_i = 4'hf;
    sys_rst_i = 1'b1;
    void'($urandom(32'h4f51));
    tick(2);
    `CHK(gp_pin_oe_o, 4'h0)
    `CHK(pbus_if_inst.b_ad_oe, 1'b0)
    sys_rst_i = 1'b0;
    tick();
    `CHK(req_ready_o, 1'b0)
    grant_i = 1'b1;
    tick();
    `CHK(req_ready_o, 1'b1)
    claim_en_i = 1'b1;
    for (int i = 0; i < 16; i++) begin
      a = $urandom;
      d = $urandom;
      be = (i < 4) ? be_tab[i] : nibble_t'($urandom);
      bridge_op(1'b1, i[0], a, d, be);
      mem_exp = merge(mem_exp, d, be);
      `CHK(ab, 1'b0)
      `CHK(mem_word_o, mem_exp)
      `CHK(lks, i[0])
      bridge_op(1'b0, 1'b0, a, ~d, 4'hf);
      `CHK(rdata_o, mem_exp)
    end
    claim_en_i = 1'b0;
    bridge_op(1'b1, 1'b0, a, ~mem_exp, 4'hf);
    `CHK(ab, 1'b1)
    `CHK(n > 3, 1'b1)
    `CHK(mem_word_o, mem_exp)
    claim_en_i = 1'b1;
    grant_i = 1'b0;
    for (int i = 0; i < 8; i++) begin
      perr_resp_en_i = i[0];
      cfg_op(i[1], (32'h0100_0000 << i) | (32'($urandom) & 32'h0000_00fc), $urandom);
      `CHK(ok, 1'b1)
      `CHK(pe, 1'b0)
      if (!i[1]) begin
        `CHK(cfg_rdata_o, 32'h0000_0000)
      end
    end
    grant_i = 1'b1;
    for (int i = 0; i < 6; i++) begin
      {gp_in_i, gp_out_i, gp_oe_i} = (i < 2) ? {12{i[0]}} : 12'($urandom);
      #1;
      `CHK(gp_pin_o, gp_out_i)
      `CHK(gp_pin_oe_o, gp_oe_i)
      tick(2);
      `CHK(gp_rd_o, gp_in_i)
    end
    tick(3);
    {req_valid_i, req_write_i, req_lock_i} = 3'b111;
    tick(2);
    req_valid_i = 1'b0;
    sys_rst_i = 1'b1;
    tick(2);
    `CHK(pbus_if_inst.lock_n, 1'b1)
    `CHK(pbus_if_inst.frame_n, 1'b1)
    sys_rst_i = 1'b0;
    bridge_op(1'b1, 1'b0, a, d, 4'hf);
    `CHK(mem_word_o, d)
    give_verdict();
  end
endmodule
